// ===== logic/smg_guard.sv
// Mode control and security row guard with APB register access
//
// The implementer's own choices: register access over APB and the register offsets.
`include "smg_params.svh"
module smg_guard (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ram_rd_valid,
   input wire logic [7:0] ram_rd_data,
   input wire logic ram_rd_par,
   input wire logic rom_rd_valid,
   input wire logic [7:0] rom_rd_data,
   input wire logic rom_rd_par,
   input wire logic app_erase_done,
   output smg_pkg::smg_mode_e cpu_mode,
   output logic sw_start_en,
   output logic cfg_valid,
   output logic par_reset,
   output logic app_erase_req,
   output logic [55:0] fuse_cfg
);
   import smg_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic acc, done_x, wr_x, row_sel, row_pend;
   smg_eng_e eng;
   smg_op_e op;
   logic [8:0] row_addr, op_addr, mem_addr;
   logic [7:0] op_wdata, mem_wbyte, cor_data, eng_rdata, crc;
   logic [11:0] mem_wcode, mem_rcode;
   logic mem_en, mem_we, ecc_fix, eng_done, eng_ref;
   logic boot_done, crc_ok, crc_fail, delivered, opt_card, opt_erase;
   logic wp_locked, card_off, ecc_flag, ref_flag;
   logic [3:0] ld_idx;
   logic [55:0] fuse_sh;
   logic [2:0] st_bits;
   smg_mode_e mode_req;
   logic mode_wr, mode_ok;
   logic [1:0] par_err;
   logic [7:0] par_data [2];
   logic [1:0] par_bit, par_vld;

   assign acc = psel && penable && !pready;
   assign done_x = psel && penable && pready;
   assign wr_x = done_x && pwrite;
   assign row_sel = paddr == `SMG_REG_DATA;

   // Area decode; the factory init area sits outside this row and is never guarded here
   function automatic logic rd_ok(input logic [8:0] a, input smg_mode_e m);
      if (a < `SMG_WO_END) begin
         return 1'b1;
      end else if (a < `SMG_CFG_END) begin
         return m == SMG_FIRM;
      end else begin
         return 1'b0;
      end
   endfunction : rd_ok

   function automatic logic wr_ok(input logic [8:0] a, input smg_mode_e m, input logic lock);
      if (a < `SMG_RO_END) begin
         return 1'b0;
      end else if (a < `SMG_WP_END) begin
         return !lock;
      end else if (a < `SMG_WO_END) begin
         return 1'b1;
      end else if (a < `SMG_CFG_END) begin
         return m == SMG_FIRM;
      end else begin
         return 1'b0;
      end
   endfunction : wr_ok

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ({r[6:0], 1'b0} ^ `SMG_CRC_POLY) : {r[6:0], 1'b0};
      end
      return r;
   endfunction : crc8

   smg_ecc u_ecc (
      .data_in(mem_wbyte),
      .code_out(mem_wcode),
      .code_in(mem_rcode),
      .data_out(cor_data),
      .fixed(ecc_fix)
   );

   smg_row_mem u_mem (
      .core_clk(core_clk),
      .ce(ce),
      .en(mem_en),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wcode),
      .rdata(mem_rcode)
   );

   // Row engine: boot load, state byte updates and software row accesses
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         eng <= ENG_IDLE;
         op <= OP_LD;
         mem_en <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 9'h000;
         mem_wbyte <= 8'h00;
         op_addr <= 9'h000;
         op_wdata <= 8'h00;
         eng_done <= 1'b0;
         eng_ref <= 1'b0;
         eng_rdata <= 8'h00;
         row_pend <= 1'b0;
         st_bits <= 3'h0;
         ld_idx <= 4'h0;
         crc <= `SMG_CRC_INIT;
         fuse_sh <= 56'h0;
         fuse_cfg <= 56'h0;
         boot_done <= 1'b0;
         crc_ok <= 1'b0;
         crc_fail <= 1'b0;
         cfg_valid <= 1'b0;
         delivered <= 1'b1;
         opt_card <= 1'b0;
         opt_erase <= 1'b0;
         wp_locked <= 1'b1;
         card_off <= 1'b0;
         sw_start_en <= 1'b0;
      end else if (ce) begin
         eng_done <= 1'b0;
         if (done_x) begin
            row_pend <= 1'b0;
         end
         case (eng)
            ENG_IDLE: begin
               if (!boot_done) begin
                  op <= OP_LD;
                  mem_en <= 1'b1;
                  mem_addr <= `SMG_LD_BASE + {5'h00, ld_idx};
                  eng <= ENG_RD;
               end else if (st_bits != 3'h0) begin
                  op <= OP_ST;
                  mem_en <= 1'b1;
                  mem_addr <= `SMG_LD_BASE;
                  eng <= ENG_RD;
               end else if (acc && row_sel && !row_pend) begin
                  row_pend <= 1'b1;
                  op <= pwrite ? OP_SWWR : OP_SWRD;
                  op_addr <= row_addr;
                  op_wdata <= pwdata[7:0];
                  if (pwrite ? wr_ok(row_addr, cpu_mode, wp_locked) : rd_ok(row_addr, cpu_mode)) begin
                     mem_en <= 1'b1;
                     mem_addr <= row_addr;
                     eng <= ENG_RD;
                  end else begin
                     eng_done <= 1'b1;
                     eng_ref <= 1'b1;
                     eng_rdata <= 8'h00;
                  end
               end
            end
            ENG_RD: begin
               mem_en <= 1'b0;
               eng <= ENG_CHK;
            end
            ENG_CHK: begin
               eng <= ENG_IDLE;
               case (op)
                  OP_LD: begin
                     ld_idx <= ld_idx + 4'h1;
                     if (ld_idx == 4'h0) begin
                        wp_locked <= cor_data[`SMG_STB_WP];
                        card_off <= cor_data[`SMG_STB_OFF];
                     end else if (ld_idx != `SMG_LD_LAST) begin
                        fuse_sh <= {cor_data, fuse_sh[55:8]};
                        crc <= crc8(crc, cor_data);
                     end else begin
                        boot_done <= 1'b1;
                        if (cor_data == crc) begin
                           crc_ok <= 1'b1;
                           cfg_valid <= 1'b1;
                           fuse_cfg <= fuse_sh;
                           delivered <= fuse_sh[`SMG_OPT_DELIV];
                           opt_card <= fuse_sh[`SMG_OPT_CARD];
                           opt_erase <= fuse_sh[`SMG_OPT_ERASE];
                           sw_start_en <= !(fuse_sh[`SMG_OPT_CARD] && card_off);
                        end else begin
                           crc_fail <= 1'b1; // Failed fuses keep the reset options; software start is enabled
                           sw_start_en <= 1'b1;
                        end
                     end
                  end
                  OP_SWRD: begin
                     eng_rdata <= cor_data;
                     eng_ref <= 1'b0;
                     eng_done <= 1'b1;
                  end
                  OP_SWWR: begin
                     if (op_addr >= `SMG_WP_END && op_addr < `SMG_WO_END
                         && (cor_data & ~op_wdata) != 8'h00) begin
                        eng_ref <= 1'b1;
                        eng_done <= 1'b1;
                     end else begin
                        mem_en <= 1'b1;
                        mem_we <= 1'b1;
                        mem_wbyte <= op_wdata;
                        eng <= ENG_WR;
                     end
                  end
                  default: begin
                     mem_en <= 1'b1;
                     mem_we <= 1'b1;
                     mem_wbyte <= cor_data | {5'h00, st_bits};
                     eng <= ENG_WR;
                  end
               endcase
            end
            default: begin
               mem_en <= 1'b0;
               mem_we <= 1'b0;
               eng <= ENG_IDLE;
               if (op == OP_SWWR) begin
                  eng_done <= 1'b1;
                  eng_ref <= 1'b0;
               end else begin
                  // Card disable takes hold at the next start-up only
                  wp_locked <= wp_locked | mem_wbyte[`SMG_STB_WP];
                  st_bits <= 3'h0;
               end
            end
         endcase
         // After the case so a new request beats the engine's clear
         if (wr_x && paddr == `SMG_REG_CTRL) begin
            st_bits <= st_bits | {1'b0, pwdata[`SMG_STB_OFF] & opt_card, pwdata[`SMG_STB_WP]};
         end
      end
   end

   // Mode requests
   assign mode_wr = wr_x && paddr == `SMG_REG_MODE;
   assign mode_req = smg_mode_e'(pwdata[1:0]);
   always_comb begin
      case (mode_req)
         SMG_BOOT: mode_ok = 1'b0;
         SMG_TEST: mode_ok = boot_done && !delivered && cpu_mode != SMG_USER;
         SMG_FIRM: mode_ok = boot_done;
         default: mode_ok = sw_start_en && (cpu_mode == SMG_TEST || cpu_mode == SMG_FIRM);
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpu_mode <= SMG_BOOT;
      end else if (ce && mode_wr && mode_ok) begin
         cpu_mode <= mode_req;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         row_addr <= 9'h000;
      end else if (ce && wr_x && paddr == `SMG_REG_ADDR) begin
         row_addr <= pwdata[8:0];
      end
   end

   // Sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ecc_flag <= 1'b0;
         ref_flag <= 1'b0;
      end else if (ce) begin
         if (wr_x && paddr == `SMG_REG_STAT) begin
            ecc_flag <= ecc_flag & !pwdata[`SMG_ST_ECC];
            ref_flag <= ref_flag & !pwdata[`SMG_ST_REF];
         end
         if (eng == ENG_CHK && ecc_fix) begin
            ecc_flag <= 1'b1;
         end
         if ((eng_done && eng_ref) || (mode_wr && !mode_ok)) begin
            ref_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         app_erase_req <= 1'b0;
      end else if (ce) begin
         if (app_erase_done) begin
            app_erase_req <= 1'b0;
         end
         if (wr_x && paddr == `SMG_REG_CTRL && pwdata[`SMG_CTL_ERASE] && opt_erase) begin
            app_erase_req <= 1'b1;
         end
      end
   end

   // Parity check per memory source; the reset request holds until chip reset
   assign par_vld = {rom_rd_valid, ram_rd_valid};
   assign par_bit = {rom_rd_par, ram_rd_par};
   assign par_data[0] = ram_rd_data;
   assign par_data[1] = rom_rd_data;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_par
         assign par_err[g] = par_vld[g] && ((^par_data[g]) != par_bit[g]);
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         par_reset <= 1'b0;
      end else if (ce && par_err != 2'b00) begin
         par_reset <= 1'b1;
      end
   end

   // APB slave: one wait state, row data waits for the engine
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (ce) begin
         pready <= 1'b0;
         if (acc) begin
            pready <= !row_sel || eng_done;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (paddr == `SMG_REG_MODE) begin
               prdata <= {23'h0, boot_done, 6'h00, cpu_mode};
            end else if (paddr == `SMG_REG_CTRL) begin
               prdata <= {29'h0, st_bits};
            end else if (paddr == `SMG_REG_STAT) begin
               prdata <= {23'h0, app_erase_req, ref_flag, ecc_flag, sw_start_en, card_off,
                          wp_locked, delivered, crc_fail, crc_ok};
            end else if (paddr == `SMG_REG_ADDR) begin
               prdata <= {23'h0, row_addr};
            end else if (row_sel) begin
               prdata <= {24'h0, eng_rdata};
               pslverr <= eng_ref;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   chk_no_boot_return: assert property (cpu_mode != SMG_BOOT |=> cpu_mode != SMG_BOOT)
      else $error("boot mode re-entered");
   chk_boot_exit_dest: assert property ($past(cpu_mode) == SMG_BOOT |-> cpu_mode != SMG_USER)
      else $error("boot left to user mode");
   chk_test_blocked: assert property (delivered && cpu_mode != SMG_TEST |=> cpu_mode != SMG_TEST)
      else $error("test mode entered after delivery");
   chk_ro_area: assert property (mem_we |-> mem_addr >= `SMG_RO_END)
      else $error("read-only byte written");
   chk_wp_lock: assert property (mem_we && op == OP_SWWR |-> !(wp_locked && mem_addr < `SMG_WP_END))
      else $error("locked byte written");
   chk_wo_monotone: assert property (mem_we && mem_addr >= `SMG_WP_END && mem_addr < `SMG_WO_END
                                     |-> (mem_wbyte & cor_data) == cor_data)
      else $error("write-once bit cleared");
   chk_cfg_firm: assert property (mem_we && mem_addr >= `SMG_WO_END && mem_addr < `SMG_CFG_END
                                  |-> cpu_mode == SMG_FIRM)
      else $error("config area written outside firmware");
   chk_hw_area: assert property (mem_we && mem_addr >= `SMG_CFG_END |-> op == OP_ST)
      else $error("software wrote hardware area");
   chk_par_reset: assert property (ce && par_err != 2'b00 |=> par_reset [*3])
      else $error("parity error did not force reset");
   chk_user_gate: assert property (!sw_start_en && cpu_mode != SMG_USER |=> cpu_mode != SMG_USER)
      else $error("software started on disabled card");
   chk_cfg_crc: assert property ($rose(cfg_valid) |-> crc_ok ##1 cfg_valid && $stable(fuse_cfg))
      else $error("config applied without crc match");

   cov_boot_to_firm: cover property (cpu_mode == SMG_BOOT ##1 cpu_mode == SMG_FIRM);
   cov_test_entry: cover property (cpu_mode == SMG_BOOT ##1 cpu_mode == SMG_TEST);
   cov_row_write: cover property (eng == ENG_WR && op == OP_SWWR);
   cov_crc_fail: cover property ($rose(crc_fail));
endmodule : smg_guard

// ===== include/smg_params.svh
// Offsets, area bounds, field positions and constants of the security row guard
`ifndef SMG_PARAMS_SVH
`define SMG_PARAMS_SVH
`define SMG_ROW_DEPTH 512
`define SMG_CODE_W 12
`define SMG_RO_END 9'h020
`define SMG_WP_END 9'h030
`define SMG_WO_END 9'h050
`define SMG_CFG_END 9'h060
`define SMG_LD_BASE 9'h1f0
`define SMG_LD_LAST 4'h8
`define SMG_CRC_POLY 8'h07
`define SMG_CRC_INIT 8'hff
`define SMG_REG_MODE 12'h000
`define SMG_REG_CTRL 12'h004
`define SMG_REG_STAT 12'h008
`define SMG_REG_ADDR 12'h00c
`define SMG_REG_DATA 12'h010
`define SMG_OPT_DELIV 0
`define SMG_OPT_CARD 1
`define SMG_OPT_ERASE 2
`define SMG_STB_WP 0
`define SMG_STB_OFF 1
`define SMG_CTL_ERASE 2
`define SMG_ST_ECC 6
`define SMG_ST_REF 7
`endif

// ===== include/smg_pkg.sv
// Types shared by the security row guard
package smg_pkg;
   typedef enum logic [1:0] {SMG_BOOT, SMG_TEST, SMG_FIRM, SMG_USER} smg_mode_e;
   typedef enum logic [1:0] {ENG_IDLE, ENG_RD, ENG_CHK, ENG_WR} smg_eng_e;
   typedef enum logic [1:0] {OP_LD, OP_SWRD, OP_SWWR, OP_ST} smg_op_e;
endpackage : smg_pkg

// ===== logic/smg_ecc.sv
// Hamming code per stored byte: encoder and single-bit correcting decoder
module smg_ecc (
   input wire logic [7:0] data_in,
   output logic [11:0] code_out,
   input wire logic [11:0] code_in,
   output logic [7:0] data_out,
   output logic fixed
);
   logic [3:0] syn;
   logic [11:0] cor;
   assign code_out = {data_in[7:4], ^data_in[7:4], data_in[3:1],
                      data_in[1] ^ data_in[2] ^ data_in[3] ^ data_in[7], data_in[0],
                      data_in[0] ^ data_in[2] ^ data_in[3] ^ data_in[5] ^ data_in[6],
                      data_in[0] ^ data_in[1] ^ data_in[3] ^ data_in[4] ^ data_in[6]};
   assign syn[0] = code_in[0] ^ code_in[2] ^ code_in[4] ^ code_in[6] ^ code_in[8] ^ code_in[10];
   assign syn[1] = code_in[1] ^ code_in[2] ^ code_in[5] ^ code_in[6] ^ code_in[9] ^ code_in[10];
   assign syn[2] = code_in[3] ^ code_in[4] ^ code_in[5] ^ code_in[6] ^ code_in[11];
   assign syn[3] = code_in[7] ^ code_in[8] ^ code_in[9] ^ code_in[10] ^ code_in[11];
   genvar i;
   generate
      for (i = 0; i < 12; i = i + 1) begin : g_fix
         assign cor[i] = code_in[i] ^ (syn == 4'(i + 1));
      end
   endgenerate
   assign data_out = {cor[11:8], cor[6:4], cor[2]};
   assign fixed = syn != 4'h0;
endmodule : smg_ecc

// ===== logic/smg_row_mem.sv
// Security row storage, coded words, registered read data
`include "smg_params.svh"
module smg_row_mem (
   input wire logic core_clk,
   input wire logic ce,
   input wire logic en,
   input wire logic we,
   input wire logic [8:0] addr,
   input wire logic [11:0] wdata,
   output logic [11:0] rdata
);
   logic [11:0] mem [`SMG_ROW_DEPTH];
   always_ff @(posedge core_clk) begin
      if (ce && en) begin
         if (we) begin
            mem[addr] <= wdata;
         end else begin
            rdata <= mem[addr];
         end
      end
   end
endmodule : smg_row_mem

// ===== sim/smg_mem_side.sv
// Memory-side partner: RAM and ROM read strobes with parity, erase completion
module smg_mem_side (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [1:0] bad,
   input wire logic app_erase_req,
   output logic ram_rd_valid,
   output logic [7:0] ram_rd_data,
   output logic ram_rd_par,
   output logic rom_rd_valid,
   output logic [7:0] rom_rd_data,
   output logic rom_rd_par,
   output logic app_erase_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   initial begin
      cnt = 8'h00;
      {ram_rd_valid, ram_rd_par, rom_rd_valid, rom_rd_par, app_erase_done} = 5'h00;
      ram_rd_data = 8'h00;
      rom_rd_data = 8'h00;
   end
   // Data moves every cycle so a stale byte outside a strobe never looks valid
   always @(posedge core_clk) begin
      cnt <= cnt + 8'h01;
      ram_rd_valid <= go;
      rom_rd_valid <= go;
      ram_rd_data <= cnt;
      rom_rd_data <= ~cnt;
      ram_rd_par <= ^cnt ^ bad[0];
      rom_rd_par <= ^cnt ^ bad[1];
      app_erase_done <= app_erase_req;
   end
endmodule : smg_mem_side

// ===== sim/smg_guard_test.sv
// Self-checking bench for the mode control and security row guard
`include "smg_params.svh"
module smg_guard_test;
   timeunit 1ns;
   timeprecision 1ps;
   import smg_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, ce = 1'b1;
   logic [1:0] bad = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, er, ram_rd_valid, ram_rd_par, rom_rd_valid, rom_rd_par;
   logic sw_start_en, cfg_valid, par_reset, app_erase_req, app_erase_done;
   logic [7:0] ram_rd_data, rom_rd_data, old;
   logic [55:0] fuse_cfg;
   smg_mode_e cpu_mode;
   int err_count = 0, check_count = 0;

   smg_guard dut (.core_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ram_rd_valid, .ram_rd_data, .ram_rd_par, .rom_rd_valid,
      .rom_rd_data, .rom_rd_par, .app_erase_done, .cpu_mode, .sw_start_en, .cfg_valid,
      .par_reset, .app_erase_req, .fuse_cfg);
   smg_mem_side mem (.core_clk, .go, .bad, .app_erase_req, .ram_rd_valid, .ram_rd_data,
      .ram_rd_par, .rom_rd_valid, .rom_rd_data, .rom_rd_par, .app_erase_done);

   initial forever #5 core_clk = ~core_clk;
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end

   task give_verdict;
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   // Request held until pready is sampled high; read data taken at that edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      rd = prdata;
      er = pslverr;
      if (n >= 100) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task row(input logic w, input logic [8:0] a, input logic [7:0] v);
      apb(1'b1, `SMG_REG_ADDR, {23'h0, a});
      apb(w, `SMG_REG_DATA, {24'h0, v});
   endtask : row

   task settle;
      repeat (2) @(negedge core_clk);
   endtask : settle

   task t_reset;
      @(posedge core_clk);
      rst_n <= 1'b0;
      bad <= 2'h0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("mode_rst", SMG_BOOT, cpu_mode);
      chk("par_rst", 0, par_reset);
      // Let the fuse and state bytes load before any row access
      repeat (40) @(posedge core_clk);
   endtask : t_reset

   // Bit errors are planted in a read-only byte, which the guard itself never writes
   task t_ecc;
      for (int i = 0; i < 13; i++) begin
         dut.u_mem.mem[9'h000] = 12'hbb8 ^ ((i == 12) ? 12'h000 : 12'h001 << i);
         row(1'b0, 9'h000, 8'h00);
         chk("ecc_data", 8'hb6, rd[7:0]);
         apb(1'b0, `SMG_REG_STAT, 0);
         chk("ecc_flag", i != 12, rd[6]);
         apb(1'b1, `SMG_REG_STAT, 32'h40);
      end
      row(1'b1, 9'h024, 8'hb6);
      chk("ecc_code", 12'hbb8, dut.u_mem.mem[9'h024]);
   endtask : t_ecc

   task t_ce;
      @(posedge core_clk);
      ce <= 1'b0;
      go <= 1'b1;
      bad <= 2'h1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("ce_freeze", 0, par_reset);
      ce <= 1'b1;
      bad <= 2'h0;
   endtask : t_ce

   task t_modes;
      apb(1'b1, 12'h7fc, 0);
      chk("unmap_err", 1, er);
      chk("unmap_rd", 0, rd);
      apb(1'b1, `SMG_REG_MODE, 2);
      settle();
      chk("to_firm", SMG_FIRM, cpu_mode);
      apb(0, `SMG_REG_STAT, 0);
      chk("cfg_valid", rd[0], cfg_valid);
      if (cfg_valid !== 1'b1) chk("fuse_cfg", 0, fuse_cfg[31:0]);
      apb(1'b1, `SMG_REG_MODE, 0);
      settle();
      chk("no_boot", SMG_FIRM, cpu_mode);
      apb(0, `SMG_REG_STAT, 0);
      chk("refused", 1, rd[7]);
      apb(1'b1, `SMG_REG_STAT, 32'h80);
      apb(0, `SMG_REG_STAT, 0);
      chk("w1c", 0, rd[7]);
      // Delivery state lives in fuses that the bench leaves erased
      old = rd[7:0];
      apb(1'b1, `SMG_REG_MODE, 1);
      settle();
      chk("test_gate", old[2] ? SMG_FIRM : SMG_TEST, cpu_mode);
      apb(1'b1, `SMG_REG_MODE, 2);
      apb(0, `SMG_REG_MODE, 0);
      chk("boot_done", 1, rd[8]);
   endtask : t_modes

   task t_rows;
      row(1'b1, 9'h005, 8'h3c);
      chk("ro_wr", 1, er);
      row(0, 9'h005, 0);
      chk("ro_rd", 0, er);
      row(0, 9'h100, 0);
      chk("hw_rd", 1, er);
      row(1'b1, 9'h024, 8'h5a);
      chk("wp_wr", 0, er);
      apb(1'b1, `SMG_REG_CTRL, 1);
      // The state byte update runs in the background for a few cycles
      repeat (6) @(posedge core_clk);
      apb(0, `SMG_REG_STAT, 0);
      chk("wp_lock", 1, rd[3]);
      row(1'b1, 9'h024, 8'ha5);
      chk("wp_ref", 1, er);
      row(0, 9'h024, 0);
      chk("wp_keep", 8'h5a, rd[7:0]);
      row(0, 9'h038, 0);
      old = rd[7:0] | 8'h01;
      row(1'b1, 9'h038, old);
      chk("wo_set", 0, er);
      row(1'b1, 9'h038, old & 8'hfe);
      chk("wo_clr", 1, er);
      row(0, 9'h038, 0);
      chk("wo_keep", old, rd[7:0]);
      row(1'b1, 9'h054, 8'h11);
      chk("cfg_firm", 0, er);
      apb(1'b1, `SMG_REG_MODE, 3);
      settle();
      chk("to_user", sw_start_en ? SMG_USER : SMG_FIRM, cpu_mode);
      row(0, 9'h054, 0);
      chk("cfg_user", cpu_mode == SMG_USER, er);
      apb(1'b1, `SMG_REG_MODE, 1);
      settle();
      chk("user_test", SMG_USER, cpu_mode);
      apb(1'b1, `SMG_REG_CTRL, 4);
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("erase_done", 0, app_erase_req);
   endtask : t_rows

   task t_par(input logic [1:0] b);
      @(posedge core_clk);
      go <= 1'b1;
      bad <= b;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("par_reset", b != 2'h0, par_reset);
   endtask : t_par

   initial begin
      // Erased row: every byte 0x00, whose code word is all zeros
      for (int i = 0; i < 512; i++) dut.u_mem.mem[i] = 12'h000;
      t_reset();
      t_ecc();
      t_modes();
      t_rows();
      t_par(2'h0);
      t_ce();
      t_par(2'h1);
      t_reset();
      t_par(2'h2);
      t_reset();
      give_verdict();
   end
endmodule : smg_guard_test
